//--- fesr_pkg.sv
/*
 * fesr_pkg: shared opcodes, timing, carriers and protect helpers for
 * the erase / suspend / resume sequencer of a serial nor flash.
 * Assumes a 40 MHz core clock and a 4 MB array made of 64 KB blocks.
 */
package fesr_pkg;

   // opcodes seen on the serial input
   localparam logic [7:0] OP_WREN = 8'h06;
   localparam logic [7:0] OP_WRDI = 8'h04;
   localparam logic [7:0] OP_WRSR = 8'h01;
   localparam logic [7:0] OP_PROG = 8'h02;
   localparam logic [7:0] OP_QPROG = 8'h32;
   localparam logic [7:0] OP_SECPROG = 8'h42;
   localparam logic [7:0] OP_SECERASE = 8'h44;
   localparam logic [7:0] OP_SERASE = 8'h20;
   localparam logic [7:0] OP_BERASE = 8'hD8;
   localparam logic [7:0] OP_CERASE_A = 8'hC7;
   localparam logic [7:0] OP_CERASE_B = 8'h60;
   localparam logic [7:0] OP_SUSPEND = 8'h75;
   localparam logic [7:0] OP_RESUME = 8'h7A;

   // frame lengths in serial clock edges
   localparam int CNT_W = 12;
   localparam logic [CNT_W-1:0] LEN_OPCODE = 12'h008;
   localparam logic [CNT_W-1:0] LEN_ADDR = 12'h020;
   localparam logic [CNT_W-1:0] LEN_MIN_DATA = 12'h028;
   localparam logic [CNT_W-1:0] LEN_MAX = 12'hFFF;

   // address layout: block index sits above the 64 KB offset
   localparam int BLK_LSB = 16;
   localparam int BLK_W = 6;
   localparam logic [BLK_W-1:0] BLK_LAST = 6'h3F;

   // self-timed durations, in microseconds, and the core rate
   localparam int unsigned CLK_MHZ = 40;
   localparam int unsigned SEC_ERASE_US = 500;
   localparam int unsigned BLK_ERASE_US = 1000;
   localparam int unsigned FULL_ERASE_US = 5000;
   localparam int unsigned PROG_US = 700;
   localparam int unsigned SEC_ERASE_CYC = SEC_ERASE_US * CLK_MHZ;
   localparam int unsigned BLK_ERASE_CYC = BLK_ERASE_US * CLK_MHZ;
   localparam int unsigned FULL_ERASE_CYC = FULL_ERASE_US * CLK_MHZ;
   localparam int unsigned PROG_CYC = PROG_US * CLK_MHZ;
   localparam logic [31:0] TMR_LAST = 32'h0000_0001;

   typedef enum logic [1:0] {
      K_SECTOR = 2'h0,
      K_BLOCK = 2'h1,
      K_CHIP = 2'h2,
      K_PROG = 2'h3
   } fesr_kind_type;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RUN = 2'b01,
      ST_HELD = 2'b11,
      ST_HELD_RUN = 2'b10
   } fesr_state_type;

   typedef struct packed {
      fesr_kind_type kind;
      logic [23:0] addr;
   } fesr_op_type;

   typedef struct packed {
      logic protect_invert;
      logic small_unit_protect;
      logic top_bottom_select;
      logic block_protect_bit2;
      logic block_protect_bit1;
      logic block_protect_bit0;
   } fesr_prot_type;

   // true when the 64 KB block lies in the protected area
   function automatic logic fesr_block_hit(fesr_prot_type p,
                                           logic [BLK_W-1:0] blk);
      logic [2:0] bp;
      logic [BLK_W:0] span;
      logic [BLK_W-1:0] idx;
      logic hit;
      bp = {p.block_protect_bit2, p.block_protect_bit1,
            p.block_protect_bit0};
      span = 7'h01 << (bp - 3'h1);
      idx = p.top_bottom_select ? blk : BLK_LAST - blk;
      if (bp == 3'h0) begin
         hit = 1'b0;
      end else if (p.small_unit_protect) begin
         hit = (idx == 6'h00);
      end else begin
         hit = ({1'b0, idx} < span);
      end
      return hit ^ p.protect_invert;
   endfunction

   // true when at least one page of the array is protected
   function automatic logic fesr_any_hit(fesr_prot_type p);
      logic [2:0] bp;
      bp = {p.block_protect_bit2, p.block_protect_bit1,
            p.block_protect_bit0};
      if (p.protect_invert) begin
         return !((bp == 3'h7) && !p.small_unit_protect);
      end
      return (bp != 3'h0);
   endfunction

endpackage

//--- fesr_sync.sv
/*
 * fesr_sync: two-stage synchroniser for the serial link pins.
 * Assumes the pins are asynchronous to core_clk; only the second
 * stage may be read by any logic.
 */
`timescale 1ns/1ps
module fesr_sync (
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // raw pins and their synchronised copies
   input wire logic [2:0] pin_in,
   output logic [2:0] pin_sync
);
   logic [2:0] meta;

   // one pair of flops per pin
   genvar i;
   generate
      for (i = 0; i < 3; i++) begin : g_bit
         always_ff @(posedge core_clk or negedge arst_n) begin
            if (!arst_n) begin
               meta[i] <= 1'b1;
               pin_sync[i] <= 1'b1;
            end else begin
               meta[i] <= pin_in[i];
               pin_sync[i] <= meta[i];
            end
         end
      end
   endgenerate
endmodule // fesr_sync

//--- fesr_sequencer.sv
/*
 * fesr_sequencer: instruction sequencing for block erase, chip erase
 * and erase/program suspend and resume inside a serial nor flash.
 * Assumes the serial clock is far slower than core_clk (8 core
 * cycles a period or more) and that the array itself acts on the
 * op_start / op_info requests; this block only times them.
 */
// Contract
// R1 - block erase is opcode D8h plus three address bytes under chip select
// R2 - block erase needs the write enable latch set beforehand
// R3 - any address inside a 64 KB block selects the whole block
// R4 - host holds chip select low for the whole erase command
// R5 - chip select must rise right after last address bit, else discarded
// R6 - chip select rise starts timed block erase with busy high till done
// R7 - write enable latch clears before the block erase finishes
// R8 - block erase refused when the block is protected
// R9 - opcode C7h or 60h alone erases the whole array to FFh
// R10 - chip erase only accepted with write enable latch at one
// R11 - chip erase needs chip select rising right after eighth bit
// R12 - busy stays visible at one through chip erase, then zero
// R13 - write enable latch is zero once chip erase completes
// R14 - chip erase refused when any page is protected
// R15 - suspend opcode 75h pauses a running sector or block erase
// R16 - suspend opcode also pauses a running page program
// R17 - while erase is paused, status write and erase opcodes are refused
// R18 - suspend during chip erase is ignored
// R19 - while program is paused, status write and program opcodes refused
// R20 - program suspend only acts while a page program runs
// R21 - resume 7Ah honoured only with paused flag one and busy zero
// R22 - accepted resume clears paused flag and raises busy within 200 ns
// R23 - host waits up to 2 us after suspend before next instruction
// R24 - entering suspend sets paused flag and drops busy
`timescale 1ns/1ps
module fesr_sequencer
   import fesr_pkg::*;
#(
   parameter int unsigned SEC_CYC = SEC_ERASE_CYC,
   parameter int unsigned BLK_CYC = BLK_ERASE_CYC,
   parameter int unsigned FULL_CYC = FULL_ERASE_CYC,
   parameter int unsigned PRG_CYC = PROG_CYC
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // serial link pins
   input wire logic sclk_pin,
   input wire logic cs_n_pin,
   input wire logic si_pin,
   // protect settings
   input wire fesr_prot_type prot,
   // status
   output logic busy_flag,
   output logic write_enable_latch,
   output logic paused_flag,
   // requests to the array, then the done and refused notices
   output logic op_start,
   output fesr_op_type op_info,
   output logic op_done,
   output logic cmd_refused
);

   logic [2:0] pin_sync;
   logic sclk_s;
   logic cs_n_s;
   logic si_s;
   logic sclk_d;
   logic cs_n_d;
   logic sclk_rise;
   logic cs_rise;
   logic [7:0] opcode;
   logic [23:0] addr;
   logic [CNT_W-1:0] bit_cnt;
   fesr_state_type state;
   fesr_op_type live_op;
   fesr_op_type held_op;
   logic [31:0] tmr;
   logic [31:0] held_tmr;
   logic [31:0] load_cyc;
   logic tmr_end;
   logic len8;
   logic len32;
   logic len_prog;
   logic erase_held;
   logic prog_held;
   logic blk_hit;
   logic do_wren;
   logic do_wrdi;
   logic do_start;
   logic do_susp;
   logic do_resm;
   logic do_refuse;
   fesr_op_type new_op;

   // the pins come from the host's domain
   fesr_sync u_sync (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .pin_in({sclk_pin, cs_n_pin, si_pin}),
      .pin_sync(pin_sync)
   );

   assign sclk_s = pin_sync[2];
   assign cs_n_s = pin_sync[1];
   assign si_s = pin_sync[0];

   // edge history of the synchronised serial clock and chip select
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         sclk_d <= 1'b0;
         cs_n_d <= 1'b1;
      end else begin
         sclk_d <= sclk_s;
         cs_n_d <= cs_n_s;
      end
   end

   // serial bits count only while selected, so a frame cut short
   // by a chip select glitch starts again from zero
   assign sclk_rise = sclk_s && !sclk_d && !cs_n_s; // see R4
   assign cs_rise = cs_n_s && !cs_n_d;

   // shift opcode then address; data bytes are only counted
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         opcode <= 8'h00;
         addr <= 24'h00_0000;
         bit_cnt <= '0;
      end else if (cs_n_s) begin
         bit_cnt <= '0;
      end else if (sclk_rise) begin
         if (bit_cnt < LEN_OPCODE) begin
            opcode <= {opcode[6:0], si_s}; // see R1
         end else if (bit_cnt < LEN_ADDR) begin
            addr <= {addr[22:0], si_s}; // see R1
         end
         if (bit_cnt != LEN_MAX) begin
            bit_cnt <= bit_cnt + 12'h001;
         end
      end
   end

   // frame length checks made when chip select rises
   assign len8 = (bit_cnt == LEN_OPCODE); // see R11
   assign len32 = (bit_cnt == LEN_ADDR); // see R5
   assign len_prog = (bit_cnt >= LEN_MIN_DATA) && (bit_cnt[2:0] == 3'h0);

   // which kind of operation is parked
   assign erase_held = paused_flag && (held_op.kind != K_PROG);
   assign prog_held = paused_flag && (held_op.kind == K_PROG);

   // the low 16 address bits are ignored: the block is the unit
   assign blk_hit = fesr_block_hit(prot, addr[BLK_LSB +: BLK_W]); // see R3

   // decode a completed frame into one action
   always_comb begin
      do_wren = 1'b0;
      do_wrdi = 1'b0;
      do_start = 1'b0;
      do_susp = 1'b0;
      do_resm = 1'b0;
      do_refuse = 1'b0;
      new_op.kind = K_BLOCK;
      new_op.addr = addr;
      if (cs_rise) begin
         case (opcode)
            OP_WREN: begin
               do_wren = len8 && !busy_flag;
            end
            OP_WRDI: begin
               do_wrdi = len8 && !busy_flag;
            end
            OP_BERASE, OP_SERASE: begin
               new_op.kind = (opcode == OP_BERASE) ? K_BLOCK : K_SECTOR;
               if (len32) begin
                  if (!busy_flag && write_enable_latch && // see R2
                      !erase_held && !blk_hit) begin // see R8 R17
                     do_start = 1'b1;
                  end else begin
                     do_refuse = 1'b1;
                  end
               end
            end
            OP_CERASE_A, OP_CERASE_B: begin
               new_op.kind = K_CHIP; // see R9
               new_op.addr = 24'h00_0000;
               if (len8) begin
                  if (!busy_flag && write_enable_latch && // see R10
                      !paused_flag && // see R17
                      !fesr_any_hit(prot)) begin // see R14
                     do_start = 1'b1;
                  end else begin
                     do_refuse = 1'b1;
                  end
               end
            end
            OP_PROG: begin
               new_op.kind = K_PROG;
               if (len_prog) begin
                  if (!busy_flag && write_enable_latch &&
                      !prog_held && !blk_hit) begin // see R19
                     do_start = 1'b1;
                  end else begin
                     do_refuse = 1'b1;
                  end
               end
            end
            OP_WRSR: begin
               do_refuse = paused_flag; // see R17 R19
            end
            OP_QPROG, OP_SECPROG: begin
               do_refuse = prog_held; // see R19
            end
            OP_SECERASE: begin
               do_refuse = erase_held; // see R17
            end
            OP_SUSPEND: begin
               // a chip erase cannot be parked, so it runs on
               do_susp = len8 && (state == ST_RUN) &&
                         (live_op.kind != K_CHIP); // see R15 R16 R18 R20
            end
            OP_RESUME: begin
               do_resm = len8 && paused_flag && !busy_flag; // see R21
            end
            default: begin
               do_refuse = 1'b0;
            end
         endcase
      end
   end

   // cycle count for the operation about to start
   always_comb begin
      case (new_op.kind)
         K_SECTOR: load_cyc = SEC_CYC;
         K_BLOCK: load_cyc = BLK_CYC; // see R6
         K_CHIP: load_cyc = FULL_CYC; // see R12
         K_PROG: load_cyc = PRG_CYC;
         default: load_cyc = BLK_CYC;
      endcase
   end

   assign tmr_end = busy_flag && (tmr == TMR_LAST);

   // self-timed countdown; a suspend parks the remainder
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         tmr <= 32'h0000_0000;
         held_tmr <= 32'h0000_0000;
      end else if (tmr_end) begin
         tmr <= 32'h0000_0000;
      end else if (do_start) begin
         tmr <= load_cyc; // see R6 R12
      end else if (do_susp) begin
         // the suspend cycle itself was spent erasing, so park one less
         held_tmr <= tmr - 32'h0000_0001; // see R24
      end else if (do_resm) begin
         tmr <= held_tmr; // see R22
      end else if (busy_flag) begin
         tmr <= tmr - 32'h0000_0001;
      end
   end

   // operation state, flags and the parked operation; completion
   // wins over a suspend landing in the same cycle, since there is
   // nothing left to park
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= ST_IDLE;
         busy_flag <= 1'b0;
         paused_flag <= 1'b0;
         live_op <= '0;
         held_op <= '0;
      end else if (tmr_end) begin
         busy_flag <= 1'b0; // see R6 R12
         state <= (state == ST_HELD_RUN) ? ST_HELD : ST_IDLE;
      end else if (do_start) begin
         busy_flag <= 1'b1; // see R6
         live_op <= new_op;
         state <= paused_flag ? ST_HELD_RUN : ST_RUN;
      end else if (do_susp) begin
         busy_flag <= 1'b0; // see R24
         paused_flag <= 1'b1; // see R24
         held_op <= live_op;
         state <= ST_HELD;
      end else if (do_resm) begin
         // busy rises on the next edge, well inside 200 ns
         paused_flag <= 1'b0; // see R22
         busy_flag <= 1'b1; // see R22
         live_op <= held_op;
         state <= ST_RUN;
      end
   end

   // the latch drops as each erase or program starts, so it stays zero
   // to the end unless a write enable arrives while the op is paused
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         write_enable_latch <= 1'b0;
      end else if (do_start) begin
         write_enable_latch <= 1'b0; // see R7 R13
      end else if (do_wren) begin
         write_enable_latch <= 1'b1; // see R2
      end else if (do_wrdi) begin
         write_enable_latch <= 1'b0;
      end
   end

   // one-cycle notices to the array and to the outside
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         op_start <= 1'b0;
         op_done <= 1'b0;
         cmd_refused <= 1'b0;
         op_info <= '0;
      end else begin
         op_start <= do_start || do_resm;
         op_done <= tmr_end;
         cmd_refused <= do_refuse;
         if (do_start) begin
            op_info <= new_op; // see R3 R9
         end else if (do_resm) begin
            op_info <= held_op;
         end
      end
   end

endmodule // fesr_sequencer

//--- fesr_sequencer_asserts.sv
/* fesr_sequencer_asserts: port-level checks of the erase sequencer.
   Assumes it is bound into fesr_sequencer and that no second op is
   started while another one is paused. */
`timescale 1ns/1ps
module fesr_sequencer_asserts
   import fesr_pkg::*;
#(
   parameter int unsigned BLK_CYC = BLK_ERASE_CYC,
   parameter int unsigned FULL_CYC = FULL_ERASE_CYC
) (
   // clock, reset and chip select
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic cs_n_pin,
   // status and array requests
   input wire logic busy_flag,
   input wire logic write_enable_latch,
   input wire logic paused_flag,
   input wire logic op_start,
   input wire fesr_op_type op_info,
   input wire logic op_done,
   input wire logic cmd_refused
);
   logic prev_paused;
   logic [31:0] busy_cnt;

   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   // a resume must not restart the count, or remainders go unchecked
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         busy_cnt <= 32'h0000_0000;
      end else if (op_start && !prev_paused) begin
         busy_cnt <= 32'h0000_0001;
      end else if (busy_flag) begin
         busy_cnt <= busy_cnt + 32'h0000_0001;
      end
   end

   // paused flag one cycle back, tells resume from fresh start
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         prev_paused <= 1'b0;
      end else begin
         prev_paused <= paused_flag;
      end
   end

   property p_start_busy; op_start |-> busy_flag && !paused_flag; endproperty
   a_start_busy: assert property (p_start_busy)
      else $error("op start without busy");
   property p_fresh_wel;
      op_start && !prev_paused |-> $past(write_enable_latch)
         && !write_enable_latch;
   endproperty
   a_fresh_wel: assert property (p_fresh_wel)
      else $error("start without latch or latch kept");
   property p_done_idle; op_done |-> !busy_flag && $past(busy_flag); endproperty
   a_done_idle: assert property (p_done_idle)
      else $error("done while busy");
   property p_busy_fall;
      $fell(busy_flag) |-> op_done || $rose(paused_flag);
   endproperty
   a_busy_fall: assert property (p_busy_fall)
      else $error("busy dropped without cause");
   property p_pause_entry;
      $rose(paused_flag) |-> !busy_flag && op_info.kind != K_CHIP;
   endproperty
   a_pause_entry: assert property (p_pause_entry)
      else $error("bad pause entry");
   property p_resume; $fell(paused_flag) |-> busy_flag && op_start; endproperty
   a_resume: assert property (p_resume)
      else $error("resume without busy");
   property p_chip_wel;
      op_done && op_info.kind == K_CHIP |-> !write_enable_latch;
   endproperty
   a_chip_wel: assert property (p_chip_wel)
      else $error("latch set after chip erase");
   property p_duration;
      op_done && op_info.kind inside {K_BLOCK, K_CHIP} |->
         busy_cnt == (op_info.kind == K_BLOCK ? BLK_CYC : FULL_CYC);
   endproperty
   a_duration: assert property (p_duration)
      else $error("erase time wrong");
   property p_cs_cause; op_start || cmd_refused |-> $past(cs_n_pin, 2); endproperty
   a_cs_cause: assert property (p_cs_cause)
      else $error("answer without chip select rise");
endmodule // fesr_sequencer_asserts

bind fesr_sequencer fesr_sequencer_asserts #(
   .BLK_CYC(BLK_CYC),
   .FULL_CYC(FULL_CYC)
) fesr_sequencer_asserts_i (
   .core_clk(core_clk), .arst_n(arst_n), .cs_n_pin(cs_n_pin),
   .busy_flag(busy_flag), .write_enable_latch(write_enable_latch),
   .paused_flag(paused_flag), .op_start(op_start), .op_info(op_info),
   .op_done(op_done), .cmd_refused(cmd_refused)
);

//--- fesr_host_model.sv
/* fesr_host_model: host side of the serial link, sending whole frames.
   Assumes core_clk at 40 MHz; one bit takes 8 core cycles (200 ns). */
`timescale 1ns/1ps
module fesr_host_model (
   // core clock used as time base
   input wire logic core_clk,
   // link pins toward the device
   output logic sclk_pin,
   output logic cs_n_pin,
   output logic si_pin
);
   // idle link: deselected, serial clock parked low
   initial begin
      sclk_pin = 1'b0;
      cs_n_pin = 1'b1;
      si_pin = 1'b0;
   end

   // one frame, msb first, driven on falling core edges only
   task automatic send(input logic [31:0] word, input int nbits);
      logic [31:0] sh;
      sh = word;
      @(negedge core_clk);
      cs_n_pin = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         si_pin = sh[31];
         sh = sh << 1;
         repeat (4) @(negedge core_clk);
         sclk_pin = 1'b1;
         repeat (4) @(negedge core_clk);
         sclk_pin = 1'b0;
      end
      repeat (4) @(negedge core_clk);
      cs_n_pin = 1'b1;
      // released data line must not keep its last level
      si_pin = ~si_pin;
      // short gap, well inside the post-suspend wait limit
      repeat (12) @(negedge core_clk);
   endtask
endmodule // fesr_host_model

//--- fesr_sequencer_test.sv
/* fesr_sequencer_test: self-checking bench for fesr_sequencer.
   Assumes fesr_host_model drives the link; durations shortened. */
`timescale 1ns/1ps
module fesr_sequencer_test
   import fesr_pkg::*;
;
   localparam int unsigned BLK_T = 400;
   localparam int unsigned FULL_T = 300;
   logic core_clk = 1'b0;
   logic arst_n, sclk_pin, cs_n_pin, si_pin, tb, hit;
   logic busy_flag, write_enable_latch, paused_flag;
   logic op_start, op_done, cmd_refused;
   fesr_prot_type prot;
   fesr_op_type op_info, last_info;
   logic [23:0] a;
   logic [2:0] bp;
   logic [7:0] ops [8] = '{OP_SERASE, OP_BERASE, OP_CERASE_A, OP_CERASE_B,
      OP_SECERASE, OP_PROG, OP_QPROG, OP_SECPROG};
   int lens [8] = '{32, 32, 8, 8, 32, 40, 40, 40};
   int bad_n [4] = '{31, 33, 9, 7};
   int num_errors = 0, checked = 0, n_start = 0, n_done = 0, n_ref = 0;
   int s0, r0, d0;

   always #12.5 core_clk = ~core_clk;

   fesr_sequencer #(.SEC_CYC(100), .BLK_CYC(BLK_T), .FULL_CYC(FULL_T),
      .PRG_CYC(400)) fesr_sequencer_i (
      .core_clk(core_clk), .arst_n(arst_n), .sclk_pin(sclk_pin),
      .cs_n_pin(cs_n_pin), .si_pin(si_pin), .prot(prot),
      .busy_flag(busy_flag), .write_enable_latch(write_enable_latch),
      .paused_flag(paused_flag), .op_start(op_start), .op_info(op_info),
      .op_done(op_done), .cmd_refused(cmd_refused));
   fesr_host_model fesr_host_model_i (.core_clk(core_clk),
      .sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin), .si_pin(si_pin));

   // pulse counters, so checks never race the one-cycle outputs
   always @(posedge core_clk) begin
      if (op_start === 1'b1) begin
         n_start <= n_start + 1;
         last_info <= op_info;
      end
      n_done <= n_done + int'(op_done === 1'b1);
      n_ref <= n_ref + int'(cmd_refused === 1'b1);
   end

   task automatic stop_test();
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] seen,
                      input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   // marks pulse counts, then sends one frame
   task automatic frame(input logic [7:0] op, input logic [23:0] ad,
                        input int n);
      s0 = n_start;
      r0 = n_ref;
      d0 = n_done;
      fesr_host_model_i.send({op, ad}, n);
   endtask

   // bounded wait for the self-timed op to end
   task automatic wait_idle();
      int i;
      for (i = 0; i < 3000 && busy_flag !== 1'b0; i++) begin
         @(negedge core_clk);
      end
      if (i == 3000) begin
         chk("idle_timeout", 1, 0);
         stop_test();
      end
      repeat (4) @(negedge core_clk);
   endtask

   // expected protection of one 64 KB block, no invert, no small unit
   function automatic logic prot_hit(input logic [2:0] b, input logic t,
                                     input logic [5:0] blk);
      logic [5:0] idx;
      idx = t ? blk : 6'h3F - blk;
      return (b != 3'h0) && ({1'b0, idx} < (7'h01 << (b - 3'h1)));
   endfunction

   // sends frames that a paused op must refuse, table slice lo..hi
   task automatic refuse_all(input int lo, input int hi);
      frame(OP_WREN, 24'h00_0000, 8);
      for (int k = lo; k <= hi; k++) begin
         frame(ops[k], 24'h20_0000, lens[k]);
         chk("paused_refuse", n_ref - r0, 1);
      end
      frame(OP_WRSR, 24'h00_0000, 16);
      chk("paused_wrsr", n_ref - r0, 1);
   endtask

   initial begin
      arst_n = 1'b0;
      prot = 6'h00;
      void'($urandom(21));
      repeat (16) @(negedge core_clk);
      arst_n = 1'b1;
      repeat (4) @(negedge core_clk);
      chk("rst", {busy_flag, write_enable_latch, paused_flag}, 0);
      frame(OP_RESUME, 24'h00_0000, 8);
      chk("resume_idle", n_start - s0, 0);
      frame(OP_SUSPEND, 24'h00_0000, 8);
      chk("suspend_idle", paused_flag, 0);
      frame(OP_WREN, 24'h00_0000, 8);
      frame(OP_WRDI, 24'h00_0000, 8);
      chk("wrdi", write_enable_latch, 0);
      frame(OP_BERASE, 24'h01_2345, 32);
      chk("no_wel", n_ref - r0, 1);
      $display("test idle_refusals done");
      for (int k = 0; k < 7; k++) begin
         a = k == 0 ? 24'h00_FFFF : k == 1 ? 24'h3F_0000 : 24'($urandom);
         a[23:22] = 2'b00;
         bp = k < 2 ? 3'h1 : 3'($urandom);
         tb = k < 2 ? k == 0 : 1'($urandom);
         prot = {2'b00, tb, bp};
         hit = prot_hit(bp, tb, a[21:16]);
         frame(OP_WREN, 24'h00_0000, 8);
         frame(OP_BERASE, a, 32);
         chk("blk_start", n_start - s0, !hit);
         chk("blk_ref", n_ref - r0, hit);
         if (!hit) begin
            chk("blk_kind", last_info.kind, K_BLOCK);
            chk("blk_addr", last_info.addr[21:16], a[21:16]);
            chk("blk_busy_wel", {busy_flag, write_enable_latch}, 2);
            wait_idle();
            chk("blk_done", n_done - d0, 1);
         end
      end
      $display("test block_erase done");
      prot = 6'h00;
      frame(OP_WREN, 24'h00_0000, 8);
      for (int k = 0; k < 4; k++) begin
         frame(ops[k < 2 ? 1 : 2], 24'h00_0000, bad_n[k]);
         chk("bad_len", n_start - s0 + n_ref - r0, 0);
      end
      chk("bad_wel", write_enable_latch, 1);
      $display("test framing done");
      for (int k = 0; k < 4; k++) begin
         prot = k == 2 ? 6'h01 : k == 3 ? 6'h27 : 6'h00;
         frame(OP_WREN, 24'h00_0000, 8);
         frame(k[0] ? OP_CERASE_B : OP_CERASE_A, 24'h00_0000, 8);
         chk("chip_ref", n_ref - r0, k == 2);
         chk("chip_start", n_start - s0, k != 2);
         if (k != 2) begin
            chk("chip_kind", last_info.kind, K_CHIP);
            frame(OP_SUSPEND, 24'h00_0000, 8);
            chk("chip_nopause", {busy_flag, paused_flag}, 2);
            wait_idle();
            chk("chip_done", n_done - d0, 1);
            chk("chip_wel", write_enable_latch, 0);
         end
      end
      $display("test chip_erase done");
      prot = 6'h00;
      for (int k = 0; k < 2; k++) begin
         frame(OP_WREN, 24'h00_0000, 8);
         frame(k ? OP_PROG : OP_BERASE, 24'h12_3456, k ? 40 : 32);
         frame(OP_SUSPEND, 24'h00_0000, 8);
         chk("sus_flags", {busy_flag, paused_flag}, 1);
         if (k == 0) refuse_all(0, 4);
         else refuse_all(5, 7);
         frame(OP_RESUME, 24'h00_0000, 8);
         chk("res_flags", {busy_flag, paused_flag}, 2);
         chk("res_kind", last_info.kind, k ? K_PROG : K_BLOCK);
         wait_idle();
         chk("res_done", n_done - d0, 1);
      end
      $display("test suspend_resume done");
      stop_test();
   end
endmodule // fesr_sequencer_test
